// ==== verilog/rdc_defines.vh ====
// What this block does
// - write-blocked flag 0 when unit can take a byte, 1 otherwise
// - reply-absent flag 0 while a reply byte waits, 1 when none waits
// - six command codes: reset, sector read, byte read, sector write, byte write, checksum
// - unknown command codes and invalid data bytes ignored, memory untouched
// - a new command abandons the current one and starts its own sequence
// - write protect on: write commands answer error, memory unchanged
// - reset command reinitialises unit then returns one status byte
// - sector read returns one status byte then 128 data bytes
// - all 128 sector-read bytes sent even after error status
// - byte read returns status then one data byte, even on error
// - sector write takes 128 data bytes, status only after data written
// - error during sector write discards data, nonzero status
// - byte write takes one data byte, nonzero status and byte ignored on error
// - checksum command checks whole memory then returns one status byte
// - two ports: low reads reply and writes data, high reads flags, writes command
// - top six bits of handshake register read as 0
// - small configuration accepts only up to track 7, sector 1f
`ifndef RDC_DEFINES_VH
`define RDC_DEFINES_VH

// port addresses
`define RDC_ADDR_DATA       8'h80
`define RDC_ADDR_FLAGS      8'h81
// handshake register fields
`define RDC_BIT_WR_BLOCKED  0
`define RDC_BIT_RPL_ABSENT  1
// command codes
`define RDC_CMD_RESET       8'h00
`define RDC_CMD_SECT_RD     8'h01
`define RDC_CMD_BYTE_RD     8'h02
`define RDC_CMD_SECT_WR     8'h03
`define RDC_CMD_BYTE_WR     8'h04
`define RDC_CMD_CHECK       8'h05
// geometry
`define RDC_SECT_BYTES      8'h80
`define RDC_TRACK_MAX_BIG   8'h0e
`define RDC_TRACK_MAX_SMALL 8'h07
`define RDC_SECT_MAX_BIG    8'h3f
`define RDC_SECT_MAX_SMALL  8'h1f
// status codes
`define RDC_STS_OK          8'h00
`define RDC_STS_PROTECT     8'h01
`define RDC_STS_RANGE       8'h02
`define RDC_STS_CHECK_ERR   8'h03
// checksum start value; the whole memory must add up to zero
`define RDC_CHECK_SEED      8'h00

`endif

// ==== verilog/rdc_mem.v ====
`timescale 1ns/10ps
`include "rdc_defines.vh"

module rdc_mem
#(
    parameter AW = 17
)
(
    input  wire          clk_sys_in,
    input  wire          ce_in,
    input  wire          we_in,
    input  wire [AW-1:0] addr_in,
    input  wire [7:0]    wdata_in,
    output reg  [7:0]    rdata_out
);
    reg [7:0] store [0:(1<<AW)-1];

    // synchronous byte storage, kept across unit reset
    always @(posedge clk_sys_in)
    begin
        if (ce_in)
        begin
            if (we_in)
                store[addr_in] <= wdata_in;
            rdata_out <= store[addr_in];
        end
    end
endmodule // rdc_mem

// ==== verilog/rdc_port.v ====
`timescale 1ns/10ps
`include "rdc_defines.vh"

module rdc_port
#(
    parameter AW = 17
)
(
    input  wire       clk_sys_in,
    input  wire       rst_n_in,
    input  wire       ce_in,
    input  wire [7:0] io_addr_in,
    input  wire       io_rd_in,
    input  wire       io_wr_in,
    input  wire [7:0] io_wdata_in,
    input  wire       write_protect_in,
    input  wire       small_config_in,
    output reg  [7:0] io_rdata_out,
    output wire       busy_out
);
    //------------------------------------------------------------
    // states
    //------------------------------------------------------------
    localparam [8:0] S_IDLE  = 9'h001;
    localparam [8:0] S_PARM  = 9'h002;
    localparam [8:0] S_WDAT  = 9'h004;
    localparam [8:0] S_COMMIT= 9'h008;
    localparam [8:0] S_RDFET = 9'h010;
    localparam [8:0] S_RDOUT = 9'h020;
    localparam [8:0] S_CHECK = 9'h040;
    localparam [8:0] S_STS   = 9'h080;
    localparam [8:0] S_RDWT  = 9'h100;

    reg  [8:0]    state;
    reg  [7:0]    cmd;
    reg  [1:0]    parm_cnt;
    reg  [7:0]    track;
    reg  [7:0]    sector;
    reg  [7:0]    cnt;
    reg  [7:0]    sbuf [0:127];
    reg  [7:0]    status;
    reg  [7:0]    reply;
    reg           reply_valid;
    reg           in_full;
    reg           in_is_cmd;
    reg  [7:0]    in_byte;
    reg  [AW-1:0] scan;
    reg  [7:0]    sum;
    reg           chk_live;
    reg           chk_end;
    reg           mem_we;
    reg  [AW-1:0] mem_addr;
    reg  [7:0]    mem_wdata;
    wire [7:0]    mem_rdata;
    wire          rd_data;
    wire          wr_data;
    wire          wr_cmd;
    wire          addr_ok;
    wire          is_write;
    wire [16:0]   byte_addr;
    wire [7:0]    sum_next;

    //------------------------------------------------------------
    // host port decode
    //------------------------------------------------------------
    // low port data, high port command
    assign rd_data = io_rd_in && (io_addr_in == `RDC_ADDR_DATA);
    assign wr_data = io_wr_in && (io_addr_in == `RDC_ADDR_DATA);
    assign wr_cmd  = io_wr_in && (io_addr_in == `RDC_ADDR_FLAGS);
    assign busy_out = in_full;

    assign addr_ok = small_config_in ?
        ((sector <= `RDC_SECT_MAX_BIG) &&
         ((track < `RDC_TRACK_MAX_SMALL) ||
          ((track == `RDC_TRACK_MAX_SMALL) && (sector <= `RDC_SECT_MAX_SMALL)))) :
        ((track <= `RDC_TRACK_MAX_BIG) && (sector <= `RDC_SECT_MAX_BIG));
    assign is_write = (cmd == `RDC_CMD_SECT_WR) || (cmd == `RDC_CMD_BYTE_WR);
    // sector byte address, cut to the memory size on purpose
    assign byte_addr = {track[3:0], sector[5:0], cnt[6:0]};
    assign sum_next  = sum + mem_rdata;

    // read mux for the host
    always @*
    begin
        io_rdata_out = 8'h00;
        if (io_addr_in == `RDC_ADDR_FLAGS)
            io_rdata_out = {6'h00, ~reply_valid, in_full};
        else if (io_addr_in == `RDC_ADDR_DATA)
            io_rdata_out = reply;
    end

    //------------------------------------------------------------
    // memory
    //------------------------------------------------------------
    always @*
    begin
        mem_we    = 1'b0;
        mem_addr  = byte_addr[AW-1:0];
        mem_wdata = sbuf[cnt[6:0]];
        if (state == S_COMMIT)
            mem_we = 1'b1;
        else if (state == S_CHECK)
            mem_addr = scan;
    end

    rdc_mem #(.AW(AW)) u_mem
    (
        .clk_sys_in (clk_sys_in),
        .ce_in      (ce_in),
        .we_in      (mem_we),
        .addr_in    (mem_addr),
        .wdata_in   (mem_wdata),
        .rdata_out  (mem_rdata)
    );

    //------------------------------------------------------------
    // command engine
    //------------------------------------------------------------
    always @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            state <= S_IDLE; cmd <= 8'h00; parm_cnt <= 2'd0;
            track <= 8'h00; sector <= 8'h00; cnt <= 8'h00;
            status <= `RDC_STS_OK; reply <= 8'h00; reply_valid <= 1'b0;
            in_full <= 1'b0; in_is_cmd <= 1'b0; in_byte <= 8'h00;
            scan <= {AW{1'b0}}; sum <= `RDC_CHECK_SEED;
            chk_live <= 1'b0;
            chk_end <= 1'b0;
        end
        else if (ce_in)
        begin
            if (rd_data && reply_valid)
                reply_valid <= 1'b0;
            // host write blocks until taken; host writes only when clear
            if ((wr_data || wr_cmd) && !in_full)
            begin
                in_full   <= 1'b1;
                in_is_cmd <= wr_cmd;
                in_byte   <= io_wdata_in;
            end
            if (in_full && in_is_cmd)
            begin
                in_full <= 1'b0;
                if (in_byte <= `RDC_CMD_CHECK)
                begin
                    cmd <= in_byte; cnt <= 8'h00; parm_cnt <= 2'd0;
                    reply_valid <= 1'b0; status <= `RDC_STS_OK;
                    case (in_byte)
                    `RDC_CMD_RESET:
                    begin
                        track <= 8'h00; sector <= 8'h00;
                        state <= S_STS;
                    end
                    `RDC_CMD_CHECK:
                    begin
                        scan <= {AW{1'b0}}; sum <= `RDC_CHECK_SEED;
                        chk_live <= 1'b0;
                        chk_end <= 1'b0;
                        state <= S_CHECK;
                    end
                    default: state <= S_PARM;
                    endcase
                end
            end
            else
            begin
                case (state)
                S_PARM:
                    if (in_full)
                    begin
                        in_full <= 1'b0;
                        if (parm_cnt == 2'd0)
                        begin
                            track <= in_byte; parm_cnt <= 2'd1;
                        end
                        else
                        begin
                            sector <= in_byte; parm_cnt <= 2'd2;
                            cnt <= 8'h00;
                            if ((cmd == `RDC_CMD_BYTE_RD) || (cmd == `RDC_CMD_BYTE_WR))
                                cnt <= 8'h00;
                            if (is_write)
                                state <= S_WDAT;
                            else
                                state <= S_STS;
                        end
                    end
                S_WDAT:
                    if (in_full)
                    begin
                        in_full <= 1'b0;
                        sbuf[cnt[6:0]] <= in_byte;
                        if ((cmd == `RDC_CMD_BYTE_WR) ||
                            (cnt == `RDC_SECT_BYTES - 8'h01))
                        begin
                            cnt <= 8'h00;
                            if (write_protect_in)
                            begin
                                status <= `RDC_STS_PROTECT; state <= S_STS;
                            end
                            else if (!addr_ok)
                            begin
                                status <= `RDC_STS_RANGE; state <= S_STS;
                            end
                            else
                                state <= S_COMMIT;
                        end
                        else
                            cnt <= cnt + 8'h01;
                    end
                S_COMMIT:
                begin
                    if ((cmd == `RDC_CMD_BYTE_WR) || (cnt == `RDC_SECT_BYTES - 8'h01))
                    begin
                        cnt <= 8'h00; state <= S_STS;
                    end
                    else
                        cnt <= cnt + 8'h01;
                end
                S_CHECK:
                begin
                    // memory answers a cycle late: add each byte one step behind
                    if (chk_live)
                        sum <= sum_next;
                    chk_live <= 1'b1;
                    scan <= scan + {{(AW-1){1'b0}}, 1'b1};
                    if (&scan)
                        chk_end <= 1'b1;
                    if (chk_end)
                    begin
                        // nonzero on mismatch, last byte included
                        status <= (sum_next == 8'h00) ? `RDC_STS_OK : `RDC_STS_CHECK_ERR;
                        state  <= S_STS;
                    end
                end
                S_STS:
                    if (!reply_valid && !(rd_data))
                    begin
                        if (!is_write && (cmd == `RDC_CMD_SECT_RD || cmd == `RDC_CMD_BYTE_RD)
                            && !addr_ok && status == `RDC_STS_OK)
                            reply <= `RDC_STS_RANGE;
                        else
                            reply <= status;
                        reply_valid <= 1'b1;
                        if ((cmd == `RDC_CMD_SECT_RD) || (cmd == `RDC_CMD_BYTE_RD))
                            state <= S_RDFET;
                        else
                            state <= S_IDLE;
                    end
                S_RDFET:
                    state <= S_RDWT;
                S_RDWT:
                    state <= S_RDOUT;
                S_RDOUT:
                    if (!reply_valid && !(rd_data))
                    begin
                        reply <= mem_rdata;
                        reply_valid <= 1'b1;
                        if ((cmd == `RDC_CMD_BYTE_RD) || (cnt == `RDC_SECT_BYTES - 8'h01))
                        begin
                            cnt <= 8'h00; state <= S_IDLE;
                        end
                        else
                        begin
                            cnt <= cnt + 8'h01; state <= S_RDFET;
                        end
                    end
                S_IDLE:
                    if (in_full)
                        in_full <= 1'b0;
                default:
                    state <= S_IDLE;
                endcase
            end
        end
    end
endmodule // rdc_port

// ==== verif/rdc_port_chk.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// handshake and read-mux checker
// ----------------------------------------
module rdc_port_chk
(
    input wire       clk_sys_in,
    input wire       rst_n_in,
    input wire       ce_in,
    input wire [7:0] io_addr_in,
    input wire       io_rd_in,
    input wire       io_wr_in,
    input wire [7:0] io_rdata_out,
    input wire       busy_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    // flags port selected, write taken
    wire flg  = (io_addr_in == 8'h81);
    wire take = ce_in && io_wr_in && !busy_out && (flg || io_addr_in == 8'h80);
    hs_top_zero_a: assert property (disable iff (!rst_n_in)
        flg |-> io_rdata_out[7:2] == 6'h00) else $error("flag top bits set");
    blk_view_a: assert property (disable iff (!rst_n_in)
        flg |-> io_rdata_out[0] == busy_out) else $error("blocked flag differs");
    wr_block_a: assert property (disable iff (!rst_n_in)
        take |=> busy_out) else $error("write did not block");
    blk_clear_a: assert property (disable iff (!rst_n_in)
        busy_out && ce_in |=> !busy_out) else $error("block held too long");
    rst_flags_a: assert property (
        !rst_n_in && ce_in |=> !busy_out && (!flg || io_rdata_out == 8'h02))
        else $error("flags wrong after reset");
    unmapped_zero_a: assert property (disable iff (!rst_n_in)
        io_addr_in != 8'h80 && !flg |-> io_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    ce_freeze_a: assert property (disable iff (!rst_n_in)
        !ce_in && flg |=> !flg || $stable(io_rdata_out)) else $error("state moved");
    reply_stays_a: assert property (disable iff (!rst_n_in)
        flg && !io_rdata_out[1] && !busy_out && !io_wr_in |=> !flg || !io_rdata_out[1])
        else $error("reply lost unread");
    cover property (take && flg);
    cover property (io_rd_in && io_addr_in == 8'h80 && ce_in);
    cover property (!ce_in && flg);
endmodule // rdc_port_chk

bind rdc_port rdc_port_chk rdc_port_chk_inst (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .ce_in(ce_in), .io_addr_in(io_addr_in),
    .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_rdata_out(io_rdata_out),
    .busy_out(busy_out));

// ==== verif/rdc_host.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// host processor on the i/o bus
// ----------------------------------------
module rdc_host
(
    input  wire       clk_sys_in,
    input  wire [7:0] io_rdata_out,
    output reg  [7:0] io_addr_in = 8'h81,
    output reg        io_rd_in = 1'b0,
    output reg        io_wr_in = 1'b0,
    output reg  [7:0] io_wdata_in = 8'h00
);
    integer stalls = 0;
    integer slow = 0;
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk_sys_in);
        io_addr_in <= a;
        io_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        d = io_rdata_out;
        io_rd_in <= 1'b0;
    endtask
    task waitf(input integer b);
        reg [7:0] f;
        integer n;
        f = 8'hff;
        n = 0;
        while (f[b] !== 1'b0 && n < 4000)
        begin
            rd(8'h81, f);
            n = n + 1;
        end
        if (n == 4000)
            stalls = stalls + 1;
    endtask
    task send(input [7:0] a, input [7:0] d);
        repeat (slow) @(posedge clk_sys_in);
        waitf(0);
        @(posedge clk_sys_in);
        io_addr_in <= a;
        io_wdata_in <= d;
        io_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        io_wr_in <= 1'b0;
        io_wdata_in <= ~d; // released bus, not last value
    endtask
    task get(output [7:0] d);
        waitf(1);
        rd(8'h80, d);
    endtask
endmodule // rdc_host

// ==== verif/rdc_port_bench.sv ====
`timescale 1ns/10ps
`include "rdc_defines.vh"
module rdc_port_bench;
    reg        clk_sys_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
    reg        write_protect_in = 1'b0, small_config_in = 1'b0;
    wire [7:0] io_addr_in, io_wdata_in, io_rdata_out;
    wire       io_rd_in, io_wr_in, busy_out;
    integer    errors = 0, n_checks = 0, i, s;
    reg  [7:0] d;
    initial forever #5 clk_sys_in = ~clk_sys_in;
    rdc_port #(.AW(10)) rdc_port_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .ce_in(ce_in), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
        .io_wdata_in(io_wdata_in), .write_protect_in(write_protect_in),
        .small_config_in(small_config_in), .io_rdata_out(io_rdata_out), .busy_out(busy_out));
    rdc_host rdc_host_inst (.clk_sys_in(clk_sys_in), .io_rdata_out(io_rdata_out),
        .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
        .io_wdata_in(io_wdata_in));
    // ----------------------------------------
    // shared steps
    // ----------------------------------------
    task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
        end
    endtask
    task tally_and_finish;
        errors = errors + rdc_host_inst.stalls;
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task cmd(input [7:0] c, input [7:0] t, input [7:0] n);
        rdc_host_inst.send(8'h81, c);
        rdc_host_inst.send(8'h80, t);
        rdc_host_inst.send(8'h80, n);
    endtask
    task st(input [7:0] e);
        rdc_host_inst.get(d);
        chk("status", e, d);
    endtask
    task idle;
        repeat (8) @(posedge clk_sys_in);
        rdc_host_inst.rd(8'h81, d);
        chk("flags", 8'h02, d);
        chk("busy", 8'h00, {7'h00, busy_out});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        idle;
        rdc_host_inst.rd(8'h82, d);
        chk("unmap", 8'h00, d);
        rdc_host_inst.send(8'h81, `RDC_CMD_RESET);
        st(`RDC_STS_OK);
        idle;
    endtask
    task t_fill;
        for (s = 0; s < 8; s = s + 1)
        begin
            cmd(`RDC_CMD_SECT_WR, 8'h00, s[7:0]);
            for (i = 0; i < 128; i = i + 1)
                rdc_host_inst.send(8'h80, (s == 1) ? i[7:0] + 8'h01 : 8'h00);
            st(`RDC_STS_OK);
        end
    endtask
    task t_read;
        cmd(`RDC_CMD_SECT_RD, 8'h00, 8'h01);
        st(`RDC_STS_OK);
        for (i = 0; i < 128; i = i + 1)
        begin
            rdc_host_inst.get(d);
            chk("sect", i[7:0] + 8'h01, d);
        end
        idle;
    endtask
    task t_protect;
        write_protect_in <= 1'b1;
        cmd(`RDC_CMD_BYTE_WR, 8'h00, 8'h02);
        rdc_host_inst.send(8'h80, 8'hff);
        st(`RDC_STS_PROTECT);
        cmd(`RDC_CMD_SECT_WR, 8'h00, 8'h01);
        for (i = 0; i < 128; i = i + 1)
            rdc_host_inst.send(8'h80, 8'hff);
        st(`RDC_STS_PROTECT);
        write_protect_in <= 1'b0;
        ce_in <= 1'b0;
        rdc_host_inst.rd(8'h81, d);
        chk("frozen", 8'h02, d);
        repeat (2) @(posedge clk_sys_in);
        ce_in <= 1'b1;
        cmd(`RDC_CMD_BYTE_RD, 8'h00, 8'h01);
        st(`RDC_STS_OK);
        rdc_host_inst.get(d);
        chk("byte", 8'h01, d);
    endtask
    task t_range;
        small_config_in <= 1'b1;
        cmd(`RDC_CMD_SECT_RD, 8'h08, 8'h00);
        st(`RDC_STS_RANGE);
        for (i = 0; i < 128; i = i + 1)
            rdc_host_inst.get(d);
        idle;
        cmd(`RDC_CMD_BYTE_RD, 8'h07, 8'h20);
        st(`RDC_STS_RANGE);
        rdc_host_inst.get(d);
        idle;
        small_config_in <= 1'b0;
        cmd(`RDC_CMD_BYTE_RD, 8'h0f, 8'h00);
        st(`RDC_STS_RANGE);
        rdc_host_inst.get(d);
    endtask
    task t_abort;
        rdc_host_inst.send(8'h81, 8'h06);
        rdc_host_inst.send(8'h81, 8'hff);
        rdc_host_inst.send(8'h80, 8'h55);
        idle;
        rdc_host_inst.slow = 3;
        cmd(`RDC_CMD_SECT_RD, 8'h00, 8'h01);
        st(`RDC_STS_OK);
        rdc_host_inst.get(d);
        chk("abort", 8'h01, d);
        rdc_host_inst.send(8'h81, `RDC_CMD_RESET);
        st(`RDC_STS_OK);
        idle;
        rdc_host_inst.slow = 0;
    endtask
    task t_check;
        cmd(`RDC_CMD_BYTE_WR, 8'h00, 8'h02);
        rdc_host_inst.send(8'h80, 8'hc0);
        st(`RDC_STS_OK);
        rdc_host_inst.send(8'h81, `RDC_CMD_CHECK);
        st(`RDC_STS_OK);
        cmd(`RDC_CMD_BYTE_WR, 8'h00, 8'h02);
        rdc_host_inst.send(8'h80, 8'hc1);
        st(`RDC_STS_OK);
        rdc_host_inst.send(8'h81, `RDC_CMD_CHECK);
        st(`RDC_STS_CHECK_ERR);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_fill;
        t_read;
        t_protect;
        t_range;
        t_abort;
        t_check;
        tally_and_finish;
    end
    initial
    begin
        repeat (60000) @(posedge clk_sys_in);
        errors = errors + 1;
        tally_and_finish;
    end
endmodule // rdc_port_bench
